// ---- core/ciomc_params.svh ----
// Register map constants for the clock input/output mode configuration bank
`ifndef CIOMC_PARAMS_SVH
`define CIOMC_PARAMS_SVH
`define CIOMC_ADDR_W            7
`define CIOMC_DATA_W            8
`define CIOMC_OFF_INPUT_MODE    7'h34
`define CIOMC_OFF_PLL2_PATH     7'h2a
`define CIOMC_OFF_AUX_FAMILY    7'h38
`define CIOMC_RST_INPUT_MODE    8'hc2
`define CIOMC_RST_PLL2_PATH     8'h40
`define CIOMC_RST_AUX_FAMILY    8'h14
`define CIOMC_MASK_INPUT_MODE   8'h24
`define CIOMC_MASK_PLL2_PATH    8'h40
`define CIOMC_MASK_AUX_FAMILY   8'h60
`define CIOMC_BIT_OSC_EDGE      5
`define CIOMC_BIT_RATE_FAMILY   2
`define CIOMC_BIT_PLL2_FB       6
`define CIOMC_BIT_AUX2_FAMILY   6
`define CIOMC_BIT_AUX1_FAMILY   5
`define CIOMC_RATE_CODE_W       4
`define CIOMC_RATE_CODE_DUAL    4'h1
`define CIOMC_STRAP_FILL        2'h3
`endif

// ---- core/ciomc_pkg.sv ----
// Types shared by the configuration bank
package ciomc_pkg;
    typedef enum logic [1:0] {
        CIOMC_RATE_OTHER,
        CIOMC_RATE_2048K,
        CIOMC_RATE_1544K
    } ciomc_rate_t;
endpackage : ciomc_pkg

// ---- core/ciomc_rate_decode.sv ----
// Expected-rate decode of one input from its rate code and the family flag
`timescale 1ns/10ps
`default_nettype none
`include "ciomc_params.svh"
module ciomc_rate_decode
    import ciomc_pkg::*;
#(
    parameter int CODE_W = `CIOMC_RATE_CODE_W
) (
    input  wire logic [CODE_W-1:0] rateCode,
    input  wire logic              rateFamily,
    output ciomc_rate_t            expectedRate
);
    // Only code 0001 depends on the family; every other code decodes to CIOMC_RATE_OTHER
    always_comb begin
        if (rateCode == CODE_W'(`CIOMC_RATE_CODE_DUAL)) begin
            expectedRate = rateFamily ? CIOMC_RATE_1544K : CIOMC_RATE_2048K;
        end else begin
            expectedRate = CIOMC_RATE_OTHER;
        end
    end
endmodule : ciomc_rate_decode
`default_nettype wire

// ---- core/ciomc_config_bank.sv ----
// Configuration register bank: oscillator edge, rate families, PLL2 feedback
`timescale 1ns/10ps
`default_nettype none
`include "ciomc_params.svh"
module ciomc_config_bank
    import ciomc_pkg::*;
#(
    parameter int ADDR_W = `CIOMC_ADDR_W,
    parameter int DATA_W = `CIOMC_DATA_W,
    parameter int CODE_W = `CIOMC_RATE_CODE_W,
    parameter int NUM_IN = 2
) (
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire logic                     regWrite,
    input  wire logic                     regRead,
    input  wire logic [ADDR_W-1:0]        regAddr,
    input  wire logic [DATA_W-1:0]        regWdata,
    output logic      [DATA_W-1:0]        regRdata,
    output logic                          regRvalid,
    input  wire logic                     rateFamilyStrap,
    input  wire logic [NUM_IN*CODE_W-1:0] inputRateCode,
    output ciomc_rate_t                   expectedRate [NUM_IN],
    output logic                          oscillator_edge_select,
    output logic                          input_rate_family_select,
    output logic                          pll2_feedback_select,
    output logic                          aux2_rate_family,
    output logic                          aux1_rate_family
);
    typedef struct packed {
        logic [DATA_W-1:0] inputMode;
        logic [DATA_W-1:0] pll2Path;
        logic [DATA_W-1:0] auxFamily;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic              strapDone;
        logic [2:0]        strapSync;
        logic [1:0]        strapFill;
    } ciomc_state_t;

    ciomc_state_t stateReg;
    ciomc_state_t stateNext;

    // Strap comes from a pin: three stages, accepted once stages two and three agree
    always_comb begin
        stateNext = stateReg;
        stateNext.strapSync = {stateReg.strapSync[1:0], rateFamilyStrap};
        stateNext.rvalid = regRead;
        stateNext.rdata = '0;
        if (regRead) begin
            case (regAddr)
                `CIOMC_OFF_INPUT_MODE: stateNext.rdata = stateReg.inputMode;
                `CIOMC_OFF_PLL2_PATH:  stateNext.rdata = stateReg.pll2Path;
                `CIOMC_OFF_AUX_FAMILY: stateNext.rdata = stateReg.auxFamily;
                default:               stateNext.rdata = '0;
            endcase
        end
        // Strap loaded once after reset release; a later software write wins from then on
        // Stage three holds the reset value until the pipe has refilled, so wait for the fill count
        if (stateReg.strapFill != `CIOMC_STRAP_FILL) begin
            stateNext.strapFill = 2'(stateReg.strapFill + 2'h1);
        end
        if (!stateReg.strapDone && (stateReg.strapFill == `CIOMC_STRAP_FILL)
            && (stateReg.strapSync[2] == stateReg.strapSync[1])) begin
            stateNext.inputMode[`CIOMC_BIT_RATE_FAMILY] = stateReg.strapSync[2];
            stateNext.strapDone = 1'b1;
        end
        if (regWrite) begin
            case (regAddr)
                `CIOMC_OFF_INPUT_MODE: begin
                    // Unused bits keep their reset value; only live bits are writable
                    stateNext.inputMode = (stateReg.inputMode & ~`CIOMC_MASK_INPUT_MODE)
                                        | (regWdata & `CIOMC_MASK_INPUT_MODE);
                    stateNext.strapDone = 1'b1;
                end
                `CIOMC_OFF_PLL2_PATH: begin
                    stateNext.pll2Path = (stateReg.pll2Path & ~`CIOMC_MASK_PLL2_PATH)
                                       | (regWdata & `CIOMC_MASK_PLL2_PATH);
                end
                `CIOMC_OFF_AUX_FAMILY: begin
                    stateNext.auxFamily = (stateReg.auxFamily & ~`CIOMC_MASK_AUX_FAMILY)
                                        | (regWdata & `CIOMC_MASK_AUX_FAMILY);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            // Rate-family bit reads 0 until the strap pipe has refilled and the pin level is taken
            stateReg.inputMode <= `CIOMC_RST_INPUT_MODE;
            stateReg.pll2Path  <= `CIOMC_RST_PLL2_PATH;
            stateReg.auxFamily <= `CIOMC_RST_AUX_FAMILY;
            stateReg.rdata     <= '0;
            stateReg.rvalid    <= 1'b0;
            stateReg.strapDone <= 1'b0;
            stateReg.strapSync <= '0;
            stateReg.strapFill <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign regRdata                 = stateReg.rdata;
    assign regRvalid                = stateReg.rvalid;
    assign oscillator_edge_select   = stateReg.inputMode[`CIOMC_BIT_OSC_EDGE];
    assign input_rate_family_select = stateReg.inputMode[`CIOMC_BIT_RATE_FAMILY];
    assign pll2_feedback_select     = stateReg.pll2Path[`CIOMC_BIT_PLL2_FB];
    assign aux2_rate_family         = stateReg.auxFamily[`CIOMC_BIT_AUX2_FAMILY];
    assign aux1_rate_family         = stateReg.auxFamily[`CIOMC_BIT_AUX1_FAMILY];

    // One decoder per input so the family flag reaches every rate-code-0001 input
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : genDecode
            ciomc_rate_decode #(
                .CODE_W(CODE_W)
            ) uDecode (
                .rateCode     (inputRateCode[gi*CODE_W +: CODE_W]),
                .rateFamily   (input_rate_family_select),
                .expectedRate (expectedRate[gi])
            );
        end
    endgenerate

    // Assertions
    chk_edge_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        regWrite && regAddr == `CIOMC_OFF_INPUT_MODE
        |=> oscillator_edge_select == $past(regWdata[`CIOMC_BIT_OSC_EDGE]))
        else $error("oscillator edge select did not follow write");
    chk_family_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
        inputRateCode[CODE_W-1:0] == CODE_W'(`CIOMC_RATE_CODE_DUAL)
        |-> expectedRate[0] == (input_rate_family_select ? CIOMC_RATE_1544K : CIOMC_RATE_2048K))
        else $error("rate code 0001 decoded to wrong rate");
    chk_other_code: assert property (@(posedge clk_sys) disable iff (!nrst)
        inputRateCode[CODE_W-1:0] != CODE_W'(`CIOMC_RATE_CODE_DUAL) |-> expectedRate[0] == CIOMC_RATE_OTHER)
        else $error("family flag leaked into other rate code");
    chk_strap_load: assert property (@(posedge clk_sys) disable iff (!nrst)
        !stateReg.strapDone && !regWrite && stateReg.strapFill == `CIOMC_STRAP_FILL
        && stateReg.strapSync[2] == stateReg.strapSync[1]
        |=> input_rate_family_select == $past(stateReg.strapSync[2]))
        else $error("strap level not loaded into rate family");
    chk_strap_once: assert property (@(posedge clk_sys) disable iff (!nrst)
        stateReg.strapDone && !regWrite |=> $stable(input_rate_family_select))
        else $error("rate family changed without a write");
    chk_pll2_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        regWrite && regAddr == `CIOMC_OFF_PLL2_PATH
        |=> pll2_feedback_select == $past(regWdata[`CIOMC_BIT_PLL2_FB]))
        else $error("PLL2 feedback select did not follow write");
    chk_aux_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        regWrite && regAddr == `CIOMC_OFF_AUX_FAMILY
        |=> {aux2_rate_family, aux1_rate_family}
            == $past({regWdata[`CIOMC_BIT_AUX2_FAMILY], regWdata[`CIOMC_BIT_AUX1_FAMILY]}))
        else $error("aux family bits did not follow write");
    chk_aux_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(regWrite && regAddr == `CIOMC_OFF_AUX_FAMILY) |=> $stable(stateReg.auxFamily))
        else $error("aux family register changed without a write");
    chk_read_back: assert property (@(posedge clk_sys) disable iff (!nrst)
        regRead && regAddr == `CIOMC_OFF_PLL2_PATH && !regWrite |=> regRvalid && regRdata == stateReg.pll2Path)
        else $error("PLL2 path read returned wrong value");
    chk_edge_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(regWrite && regAddr == `CIOMC_OFF_INPUT_MODE) |=> $stable(oscillator_edge_select))
        else $error("oscillator edge select changed without a write");

    // Unused bits are pinned to their reset values so no write can park stray state in them
    chk_input_fixed: assert property (@(posedge clk_sys) disable iff (!nrst)
        (stateReg.inputMode & ~`CIOMC_MASK_INPUT_MODE) == (`CIOMC_RST_INPUT_MODE & ~`CIOMC_MASK_INPUT_MODE))
        else $error("read-only input mode bits moved");
    chk_pll2_fixed: assert property (@(posedge clk_sys) disable iff (!nrst)
        (stateReg.pll2Path & ~`CIOMC_MASK_PLL2_PATH) == (`CIOMC_RST_PLL2_PATH & ~`CIOMC_MASK_PLL2_PATH))
        else $error("read-only PLL2 path bits moved");
    chk_aux_fixed: assert property (@(posedge clk_sys) disable iff (!nrst)
        (stateReg.auxFamily & ~`CIOMC_MASK_AUX_FAMILY) == (`CIOMC_RST_AUX_FAMILY & ~`CIOMC_MASK_AUX_FAMILY))
        else $error("read-only aux family bits moved");

    // Until the pipe has refilled, stage three holds the reset value and not a pin sample
    chk_strap_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
        stateReg.strapFill != `CIOMC_STRAP_FILL && !regWrite |=> $stable(input_rate_family_select))
        else $error("rate family loaded before the strap pipe was full");
    chk_strap_take: assert property (@(posedge clk_sys) disable iff (!nrst)
        stateReg.strapFill == `CIOMC_STRAP_FILL && stateReg.strapSync[2] == stateReg.strapSync[1]
        |=> stateReg.strapDone)
        else $error("agreeing strap stages were never taken");
    chk_strap_cancel: assert property (@(posedge clk_sys) disable iff (!nrst)
        !stateReg.strapDone && regWrite && regAddr == `CIOMC_OFF_INPUT_MODE
        |=> input_rate_family_select == $past(regWdata[`CIOMC_BIT_RATE_FAMILY]))
        else $error("software write lost to a late strap load");

    // The second decoder must see the same family flag as the first
    chk_family_in1: assert property (@(posedge clk_sys) disable iff (!nrst)
        inputRateCode[2*CODE_W-1:CODE_W] == CODE_W'(`CIOMC_RATE_CODE_DUAL)
        |-> expectedRate[1] == (input_rate_family_select ? CIOMC_RATE_1544K : CIOMC_RATE_2048K))
        else $error("second input decoded to wrong rate");

    // Read data stands for the one cycle after the strobe and is zero otherwise
    chk_read_input: assert property (@(posedge clk_sys) disable iff (!nrst)
        regRead && regAddr == `CIOMC_OFF_INPUT_MODE |=> regRdata == $past(stateReg.inputMode))
        else $error("input mode read returned wrong value");
    chk_read_aux: assert property (@(posedge clk_sys) disable iff (!nrst)
        regRead && regAddr == `CIOMC_OFF_AUX_FAMILY |=> regRdata == $past(stateReg.auxFamily))
        else $error("aux family read returned wrong value");
    chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (!nrst)
        regRead && regAddr != `CIOMC_OFF_INPUT_MODE && regAddr != `CIOMC_OFF_PLL2_PATH
        && regAddr != `CIOMC_OFF_AUX_FAMILY |=> regRvalid && regRdata == '0)
        else $error("unmapped read returned data");
    chk_rvalid_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
        !regRead |=> !regRvalid && regRdata == '0)
        else $error("read data stood without a read strobe");

    // Main scenarios
    cov_edge_fall: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(oscillator_edge_select));
    cov_write_read: cover property (@(posedge clk_sys) disable iff (!nrst) regWrite && regRead);
    cov_sonet_in:  cover property (@(posedge clk_sys) disable iff (!nrst) expectedRate[1] == CIOMC_RATE_1544K);
    cov_analog_fb: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(pll2_feedback_select));
    cov_aux_sonet: cover property (@(posedge clk_sys) disable iff (!nrst) aux1_rate_family && aux2_rate_family);
endmodule : ciomc_config_bank
`default_nettype wire

// ---- dv/ciomc_config_bank_tb.sv ----
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
`default_nettype none
`include "ciomc_params.svh"
module ciomc_config_bank_tb
    import ciomc_pkg::*;
;
    typedef struct packed {
        logic [6:0] a;
        logic [7:0] w;
        logic [7:0] r;
        logic [7:0] c;
        logic [4:0] o;
    } ciomc_row_t;
    // Outputs packed as {osc edge, rate family, pll2 fb, aux2, aux1}; state carries across rows
    localparam ciomc_row_t ROWS [9] = '{
        '{7'h38, 8'h60, 8'h74, 8'h11, 5'h0f}, '{7'h38, 8'h40, 8'h54, 8'h01, 5'h0e},
        '{7'h38, 8'h20, 8'h34, 8'h10, 5'h0d}, '{7'h34, 8'h20, 8'he2, 8'h31, 5'h15},
        '{7'h34, 8'hff, 8'he6, 8'h11, 5'h1d}, '{7'h2a, 8'h00, 8'h00, 8'h00, 5'h19},
        '{7'h2a, 8'hff, 8'h40, 8'h1f, 5'h1d}, '{7'h10, 8'hff, 8'h00, 8'h11, 5'h1d},
        '{7'h34, 8'h00, 8'hc2, 8'h11, 5'h05}};
    logic        clk_sys   = 1'b0;
    logic        nrst      = 1'b0;
    logic        regWrite  = 1'b0;
    logic        regRead   = 1'b0;
    logic [6:0]  regAddr   = 7'h00;
    logic [7:0]  regWdata  = 8'h00;
    logic        strap     = 1'b0;
    logic [7:0]  rateCode  = 8'h00;
    logic [7:0]  regRdata;
    logic        regRvalid;
    ciomc_rate_t expRate [2];
    logic        osc, rf, fb, aux2, aux1;
    int          num_errors = 0;
    int          n_checks   = 0;
    int          cycles     = 0;
    ciomc_config_bank u_ciomc_config_bank (.clk_sys(clk_sys), .nrst(nrst), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .regRvalid(regRvalid), .rateFamilyStrap(strap), .inputRateCode(rateCode),
        .expectedRate(expRate), .oscillator_edge_select(osc), .input_rate_family_select(rf),
        .pll2_feedback_select(fb), .aux2_rate_family(aux2), .aux1_rate_family(aux1));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chkRate(input ciomc_rate_t got, input ciomc_rate_t exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkRate
    // Only code 0001 depends on the family flag
    function automatic ciomc_rate_t rateOf(input logic [3:0] c, input logic f);
        if (c != `CIOMC_RATE_CODE_DUAL) return CIOMC_RATE_OTHER;
        return f ? CIOMC_RATE_1544K : CIOMC_RATE_2048K;
    endfunction : rateOf
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        chk8({7'h00, regRvalid}, 8'h01);
        chk8(regRdata, exp);
    endtask : rd
    // Strap is set with reset and held; the eight-cycle wait after release lets the strap pipe refill and load it before the first read
    task automatic rst(input logic s);
        @(posedge clk_sys);
        nrst  <= 1'b0;
        strap <= s;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        chk8({3'h0, osc, rf, fb, aux2, aux1}, {4'h0, s, 3'h4});
        rd(`CIOMC_OFF_INPUT_MODE, {5'h18, s, 2'h2});
        rd(`CIOMC_OFF_PLL2_PATH, `CIOMC_RST_PLL2_PATH);
        rd(`CIOMC_OFF_AUX_FAMILY, `CIOMC_RST_AUX_FAMILY);
    endtask : rst
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        rst(1'b1);
        foreach (ROWS[i]) begin
            @(posedge clk_sys);
            rateCode <= ROWS[i].c;
            wr(ROWS[i].a, ROWS[i].w);
            chk8({3'h0, osc, rf, fb, aux2, aux1}, {3'h0, ROWS[i].o});
            chkRate(expRate[0], rateOf(ROWS[i].c[3:0], ROWS[i].o[3]));
            chkRate(expRate[1], rateOf(ROWS[i].c[7:4], ROWS[i].o[3]));
            rd(ROWS[i].a, ROWS[i].r);
        end
        // Write and read in one cycle: the read sees the old value
        @(posedge clk_sys);
        {regWrite, regRead, regAddr, regWdata} <= {2'b11, 7'h38, 8'h40};
        @(posedge clk_sys);
        {regWrite, regRead} <= 2'b00;
        #1;
        chk8(regRdata, 8'h34);
        chk8({3'h0, osc, rf, fb, aux2, aux1}, 8'h06);
        rst(1'b0);
        results();
    end
endmodule : ciomc_config_bank_tb
`default_nettype wire
